// >>> src/pgcr_params.svh
`ifndef PGCR_PARAMS_SVH
`define PGCR_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define PGCR_ADDR_GLOBAL_COMMAND   8'h1A
`define PGCR_ADDR_IDENTIFICATION   8'h1B
`define PGCR_ADDR_HP_CLASS_ENABLE  8'h1C
`define PGCR_ADDR_RESERVED_1D      8'h1D
`define PGCR_ADDR_LIMIT_TIMEOUT_12 8'h1E
`define PGCR_ADDR_LIMIT_TIMEOUT_34 8'h1F
`define PGCR_ADDR_MISC_CONFIG_TWO  8'h29

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PGCR_BIT_CLEAR_EVENTS      7
`define PGCR_BIT_CLEAR_PIN         6
`define PGCR_BIT_CMD_RESERVED      5
`define PGCR_BIT_SOFT_RESET        4
`define PGCR_BIT_LOAD_STAB         4
`define PGCR_PORT_MASK             8'h0F
`define PGCR_MISC2_MASK            8'h1F

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define PGCR_RST_ZERO              8'h00
`define PGCR_RST_HP_CLASS_STRAP    8'h0F
// Device code value is arbitrary.
`define PGCR_DEVICE_CODE           5'h05
// Revision value is arbitrary.
`define PGCR_REVISION              3'h1

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define PGCR_CLOCK_MHZ             100
`define PGCR_LIMIT_TIMEOUT_FIELD_DEFAULT_US       60000
`define PGCR_LIMIT_TIMEOUT_FIELD_STEP_US          1710
`define PGCR_LIMIT_TIMEOUT_FIELD_STEP_CYCLES      (`PGCR_LIMIT_TIMEOUT_FIELD_STEP_US * `PGCR_CLOCK_MHZ)
`define PGCR_LIMIT_TIMEOUT_FIELD_DEFAULT_CYCLES   (`PGCR_LIMIT_TIMEOUT_FIELD_DEFAULT_US * `PGCR_CLOCK_MHZ)
// Soft reset is held this many cycles before registers are released.
`define PGCR_SOFT_RESET_CYCLES     4'h8

`endif

// >>> src/pgcr_pkg.sv
package pgcr_pkg;
  typedef logic [7:0] pgcr_byte_t;
  typedef logic [3:0] pgcr_port_t;
  typedef enum logic [2:0]
  {
    PGCR_IDLE  = 3'b001,
    PGCR_RESET = 3'b010,
    PGCR_DONE  = 3'b100
  } pgcr_state_e;
endpackage

// >>> src/pgcr_timeout_decode.sv
`timescale 1ns/1ps
`include "pgcr_params.svh"
module pgcr_timeout_decode
  import pgcr_pkg::*;
(
  input  wire logic [3:0]  limitTimeoutField,
  output logic      [31:0] timeoutCycles
);
  // ---------------------------------------------------------------
  // Field to cycles
  // ---------------------------------------------------------------
  always_comb
  begin
    if (limitTimeoutField == 4'h0)
    begin
      timeoutCycles = 32'(`PGCR_LIMIT_TIMEOUT_FIELD_DEFAULT_CYCLES);
    end
    else
    begin
      timeoutCycles = 32'(`PGCR_LIMIT_TIMEOUT_FIELD_STEP_CYCLES) * {28'h0000000, limitTimeoutField};
    end
  end
endmodule // pgcr_timeout_decode

// >>> src/pgcr_regs.sv
`timescale 1ns/1ps
`include "pgcr_params.svh"
module pgcr_regs
  import pgcr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  output logic      [7:0]  regRdata,
  input  wire logic        highPowerClassStrap,
  input  wire logic [3:0]  portPowered,
  output logic             clearAllEvents,
  output logic             clearAlertPin,
  output logic             softResetActive,
  output logic      [3:0]  portReset,
  output logic      [3:0]  portShutdown,
  output logic      [3:0]  highPowerClassPortEnable,
  output logic      [31:0] limitTimeoutCycles [4],
  output logic             loadStabilityCheckEnable,
  output logic      [3:0]  supplyRailReadoutEnable
);
  pgcr_byte_t  commandQ;
  pgcr_byte_t  hpClassQ;
  pgcr_byte_t  timeout12Q;
  pgcr_byte_t  timeout34Q;
  pgcr_byte_t  misc2Q;
  pgcr_state_e stateQ;
  logic [3:0]  resetCountQ;
  logic        anyReset;
  logic        writeCmd;
  logic [3:0]  fields [4];

  assign anyReset = rst | softResetActive;
  assign writeCmd = regWrite && (regAddr == `PGCR_ADDR_GLOBAL_COMMAND);

  // ---------------------------------------------------------------
  // Command register: pulses last one cycle, then self clear
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (anyReset)
    begin
      commandQ <= `PGCR_RST_ZERO;
    end
    else if (writeCmd)
    begin
      // Reserved bit 5 is dropped so it never acts or reads back.
      commandQ <= regWdata & ~(8'h01 << `PGCR_BIT_CMD_RESERVED);
    end
    else
    begin
      commandQ <= `PGCR_RST_ZERO;
    end
  end

  assign clearAllEvents = commandQ[`PGCR_BIT_CLEAR_EVENTS];
  assign clearAlertPin  = commandQ[`PGCR_BIT_CLEAR_PIN];
  assign portReset      = commandQ[3:0];
  assign portShutdown   = commandQ[3:0] & portPowered;

  // ---------------------------------------------------------------
  // Soft reset sequencer
  // ---------------------------------------------------------------
  // The sequencer sits on the pin reset only, so it can hold the
  // register file in reset for a fixed span and then release it.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stateQ      <= PGCR_IDLE;
      resetCountQ <= 4'h0;
    end
    else
    begin
      case (stateQ)
        PGCR_IDLE:
        begin
          if (commandQ[`PGCR_BIT_SOFT_RESET])
          begin
            stateQ      <= PGCR_RESET;
            resetCountQ <= 4'h0;
          end
        end
        PGCR_RESET:
        begin
          resetCountQ <= resetCountQ + 4'h1;
          if (resetCountQ == `PGCR_SOFT_RESET_CYCLES - 4'h1)
          begin
            stateQ <= PGCR_DONE;
          end
        end
        PGCR_DONE:
        begin
          stateQ <= PGCR_IDLE;
        end
        default:
        begin
          stateQ <= PGCR_IDLE;
        end
      endcase
    end
  end

  assign softResetActive = (stateQ == PGCR_RESET);

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (anyReset)
    begin
      hpClassQ <= highPowerClassStrap ? `PGCR_RST_HP_CLASS_STRAP : `PGCR_RST_ZERO;
    end
    else if (regWrite && (regAddr == `PGCR_ADDR_HP_CLASS_ENABLE))
    begin
      hpClassQ <= regWdata & `PGCR_PORT_MASK;
    end
  end

  always_ff @(posedge clock)
  begin
    if (anyReset)
    begin
      timeout12Q <= `PGCR_RST_ZERO;
      timeout34Q <= `PGCR_RST_ZERO;
    end
    else if (regWrite && (regAddr == `PGCR_ADDR_LIMIT_TIMEOUT_12))
    begin
      timeout12Q <= regWdata;
    end
    else if (regWrite && (regAddr == `PGCR_ADDR_LIMIT_TIMEOUT_34))
    begin
      timeout34Q <= regWdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (anyReset)
    begin
      misc2Q <= `PGCR_RST_ZERO;
    end
    else if (regWrite && (regAddr == `PGCR_ADDR_MISC_CONFIG_TWO))
    begin
      misc2Q <= regWdata & `PGCR_MISC2_MASK;
    end
  end

  assign highPowerClassPortEnable = hpClassQ[3:0];
  assign loadStabilityCheckEnable = misc2Q[`PGCR_BIT_LOAD_STAB];
  assign supplyRailReadoutEnable  = misc2Q[3:0];

  // Port 1 and 3 sit in the low nibble, ports 2 and 4 in the high one.
  assign fields[0] = timeout12Q[3:0];
  assign fields[1] = timeout12Q[7:4];
  assign fields[2] = timeout34Q[3:0];
  assign fields[3] = timeout34Q[7:4];

  // ---------------------------------------------------------------
  // Timeout decode per port
  // ---------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 4; p++)
    begin : gTimeout
      pgcr_timeout_decode uDecode
      (
        .limitTimeoutField (fields[p]),
        .timeoutCycles     (limitTimeoutCycles[p])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Reserved 1Dh and the 20h-2Fh holes read zero; writes there are
  // dropped, so host batch writes of 00h through them are harmless.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      regRdata <= `PGCR_RST_ZERO;
    end
    else if (regRead)
    begin
      case (regAddr)
        `PGCR_ADDR_GLOBAL_COMMAND:   regRdata <= commandQ;
        `PGCR_ADDR_IDENTIFICATION:   regRdata <= {`PGCR_DEVICE_CODE, `PGCR_REVISION};
        `PGCR_ADDR_HP_CLASS_ENABLE:  regRdata <= hpClassQ;
        `PGCR_ADDR_LIMIT_TIMEOUT_12: regRdata <= timeout12Q;
        `PGCR_ADDR_LIMIT_TIMEOUT_34: regRdata <= timeout34Q;
        `PGCR_ADDR_MISC_CONFIG_TWO:  regRdata <= misc2Q;
        default:                     regRdata <= `PGCR_RST_ZERO;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Soft reset also clears the command byte, so checks on command
  // pulses are switched off while either reset is active, except cmd_selfclear_a and port_shutdown_a (pin reset only).
  cmd_selfclear_a: assert property (@(posedge clock) disable iff (rst)
    commandQ != 8'h00 && !writeCmd |=> commandQ == 8'h00)
    else $error("command bits did not self clear");
  clear_events_a: assert property (@(posedge clock) disable iff (anyReset)
    writeCmd && regWdata[7] |=> clearAllEvents ##1 (!clearAllEvents || $past(writeCmd)))
    else $error("clear events pulse wrong");
  clear_pin_a: assert property (@(posedge clock) disable iff (anyReset)
    writeCmd && regWdata[6] |=> clearAlertPin)
    else $error("clear pin pulse missing");
  pin_only_a: assert property (@(posedge clock) disable iff (anyReset)
    writeCmd && regWdata[7:6] == 2'b01 |=> clearAlertPin && !clearAllEvents)
    else $error("pin clear also cleared events");
  port_reset_a: assert property (@(posedge clock) disable iff (anyReset)
    writeCmd |=> portReset == $past(regWdata[3:0]))
    else $error("port reset mismatch");
  port_shutdown_a: assert property (@(posedge clock) disable iff (rst)
    portShutdown == (portReset & portPowered))
    else $error("port shutdown mismatch");
  port_power_a: assert property (@(posedge clock) disable iff (anyReset)
    writeCmd |=> portShutdown == ($past(regWdata[3:0]) & portPowered))
    else $error("powered port not shut down");

  // The sequencer holds the registers for a fixed span, then lets go;
  // the strap is taken again on every pass through reset.
  soft_start_a: assert property (@(posedge clock) disable iff (rst)
    writeCmd && regWdata[4] && !softResetActive |=> ##1 softResetActive)
    else $error("soft reset did not start");
  soft_reset_a: assert property (@(posedge clock) disable iff (rst)
    $rose(softResetActive) |-> softResetActive [*8] ##1 !softResetActive)
    else $error("soft reset span wrong");
  soft_defaults_a: assert property (@(posedge clock) disable iff (rst)
    $fell(softResetActive) |-> commandQ == 8'h00 && timeout12Q == 8'h00
      && timeout34Q == 8'h00 && misc2Q == 8'h00
      && hpClassQ == ($past(highPowerClassStrap) ? 8'h0F : 8'h00))
    else $error("soft reset left a register off default");
  strap_reset_a: assert property (@(posedge clock)
    rst |=> hpClassQ == ($past(highPowerClassStrap) ? 8'h0F : 8'h00))
    else $error("class enable reset wrong");

  // Register contents and read back; expected values are written out
  // from the field layout rather than taken from the decode.
  ident_value_a: assert property (@(posedge clock) disable iff (rst)
    regRead && regAddr == 8'h1B |=> regRdata == 8'h29)
    else $error("identification wrong");
  reserved_read_a: assert property (@(posedge clock) disable iff (rst)
    regRead && regAddr == 8'h1D |=> regRdata == 8'h00)
    else $error("reserved address read not zero");
  class_write_a: assert property (@(posedge clock) disable iff (anyReset)
    regWrite && regAddr == 8'h1C |=> hpClassQ == {4'h0, $past(regWdata[3:0])})
    else $error("class enable write lost");
  timeout_write_a: assert property (@(posedge clock) disable iff (anyReset)
    regWrite && regAddr == 8'h1E |=> timeout12Q == $past(regWdata))
    else $error("timeout write lost");
  misc_write_a: assert property (@(posedge clock) disable iff (anyReset)
    regWrite && regAddr == 8'h29 |=> misc2Q == {3'h0, $past(regWdata[4:0])})
    else $error("misc config write lost");
  misc_reserved_a: assert property (@(posedge clock) disable iff (rst)
    misc2Q[7:5] == 3'h0 && hpClassQ[7:4] == 4'h0 && commandQ[5] == 1'b0)
    else $error("reserved bits set");
  timeout_decode_a: assert property (@(posedge clock) disable iff (rst)
    limitTimeoutCycles[1] == (timeout12Q[7:4] == 4'h0 ? 32'd6000000
      : 32'd171000 * {28'h0, timeout12Q[7:4]}))
    else $error("timeout decode wrong");
  timeout_port1_a: assert property (@(posedge clock) disable iff (rst)
    limitTimeoutCycles[0] == (timeout12Q[3:0] == 4'h0 ? 32'd6000000
      : 32'd171000 * {28'h0, timeout12Q[3:0]}))
    else $error("port one timeout decode wrong");

  // Main scenarios.
  soft_reset_c: cover property (@(posedge clock) $fell(softResetActive));
  port_reset_c: cover property (@(posedge clock) |portShutdown);
  clear_events_c: cover property (@(posedge clock) clearAllEvents && clearAlertPin);
  class_write_c: cover property (@(posedge clock) regWrite && regAddr == 8'h1C);
  timeout_max_c: cover property (@(posedge clock) limitTimeoutCycles[1] == 32'd2565000);
endmodule // pgcr_regs

// >>> test/pgcr_host.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host side of the register access strobes
// ---------------------------------------------------------------
module pgcr_host
(
  input  wire logic       clock,
  input  wire logic [7:0] regRdata,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWdata
);
  initial
  begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 8'h00;
    regWdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    regAddr = a;
    // Reserved places are internally connected, so a walk through them only ever writes zero.
    regWdata = (a == 8'h1D || (a >= 8'h20 && a <= 8'h2F && a != 8'h29)) ? 8'h00 : d;
    regWrite = 1'b1;
    @(posedge clock);
    #1;
    regWrite = 1'b0;
    regWdata = ~regWdata;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    regAddr = a;
    regRead = 1'b1;
    @(posedge clock);
    #1;
    regRead = 1'b0;
    d       = regRdata;
  endtask
endmodule // pgcr_host

// >>> test/tb.sv
`timescale 1ns/1ps
`include "pgcr_params.svh"
module tb;
  import pgcr_pkg::*;
  logic        clock, rst, regWrite, regRead, highPowerClassStrap;
  logic        clearAllEvents, clearAlertPin, softResetActive, loadStabilityCheckEnable;
  logic [7:0]  regAddr, regWdata, regRdata;
  logic [3:0]  portPowered, portReset, portShutdown;
  logic [3:0]  highPowerClassPortEnable, supplyRailReadoutEnable;
  logic [31:0] limitTimeoutCycles [4];
  int          errCount, comparisons, cycleCount, nHigh;
  int          mdl [256];
  logic [7:0]  rdAddrs [9] = '{8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h29, 8'h2F};
  logic [7:0]  wrAddrs [8] = '{8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h29, 8'h2F};
  logic [7:0]  cmds    [5] = '{8'h80, 8'h40, 8'h20, 8'h0F, 8'hC5};

  pgcr_regs u_dut (.clock(clock), .rst(rst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .highPowerClassStrap(highPowerClassStrap), .portPowered(portPowered),
    .clearAllEvents(clearAllEvents), .clearAlertPin(clearAlertPin),
    .softResetActive(softResetActive), .portReset(portReset), .portShutdown(portShutdown),
    .highPowerClassPortEnable(highPowerClassPortEnable),
    .limitTimeoutCycles(limitTimeoutCycles),
    .loadStabilityCheckEnable(loadStabilityCheckEnable),
    .supplyRailReadoutEnable(supplyRailReadoutEnable));

  pgcr_host u_host (.clock(clock), .regRdata(regRdata), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata));

  // ---------------------------------------------------------------
  // Checking helpers and reference model
  // ---------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errCount++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] tl(input int n);
    return (n == 0) ? 32'd6000000 : 32'(171000 * n);
  endfunction

  function automatic void initMdl();
    foreach (mdl[i]) mdl[i] = 0;
    mdl[8'h1B] = 32'({`PGCR_DEVICE_CODE, `PGCR_REVISION});
    mdl[8'h1C] = highPowerClassStrap ? 32'h0F : 32'h00;
  endfunction

  task automatic wrm(input logic [7:0] a, input logic [7:0] d);
    u_host.wr(a, d);
    case (a)
      8'h1C: mdl[a] = 32'(d & 8'h0F);
      8'h1E, 8'h1F: mdl[a] = 32'(d);
      8'h29: mdl[a] = 32'(d & 8'h1F);
      default: ;
    endcase
  endtask

  task automatic rdm(input logic [7:0] a);
    logic [7:0] got;
    u_host.rd(a, got);
    chk(32'(got), 32'(mdl[a]));
  endtask

  task automatic chkOut();
    chk(32'(highPowerClassPortEnable), 32'(mdl[8'h1C] & 15));
    chk(32'(loadStabilityCheckEnable), 32'((mdl[8'h29] >> 4) & 1));
    chk(32'(supplyRailReadoutEnable), 32'(mdl[8'h29] & 15));
    for (int i = 0; i < 4; i++)
      chk(limitTimeoutCycles[i], tl((mdl[8'h1E + i / 2] >> (4 * (i % 2))) & 15));
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ---------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycleCount++;
    if (cycleCount == 5000)
    begin
      errCount++;
      $display("wrong value at %0t: run did not finish", $time);
      results();
    end
  end

  initial
  begin
    void'($urandom(32'h673B));
    rst = 1'b1;
    highPowerClassStrap = 1'b0;
    portPowered = 4'h0;
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    initMdl();
    foreach (rdAddrs[i]) rdm(rdAddrs[i]);
    chkOut();
    repeat (4)
    begin
      foreach (wrAddrs[i]) wrm(wrAddrs[i], 8'($urandom));
      foreach (rdAddrs[i]) rdm(rdAddrs[i]);
      chkOut();
    end
    for (int n = 0; n < 16; n++)
    begin
      wrm(8'h1E, {n[3:0], 4'(15 - n)});
      wrm(8'h1F, 8'($urandom));
      chkOut();
    end
    foreach (cmds[i])
    begin
      portPowered = 4'($urandom);
      wrm(8'h1A, cmds[i]);
      chk(32'(clearAllEvents), 32'(cmds[i][7]));
      chk(32'(clearAlertPin), 32'(cmds[i][6]));
      chk(32'(portReset), 32'(cmds[i][3:0]));
      chk(32'(portShutdown), 32'(cmds[i][3:0] & portPowered));
      chk(32'(softResetActive), 32'h0);
      @(posedge clock);
      #1;
      chk(32'({clearAllEvents, clearAlertPin, portReset}), 32'h0);
      rdm(8'h1A);
    end
    // The strap is raised before the soft reset so that its resample is visible.
    highPowerClassStrap = 1'b1;
    wrm(8'h1A, 8'h10);
    nHigh = 0;
    repeat (20)
    begin
      @(posedge clock);
      #1;
      if (softResetActive === 1'b1)
        nHigh++;
    end
    chk(32'(nHigh), 32'd8);
    initMdl();
    foreach (rdAddrs[i]) rdm(rdAddrs[i]);
    chkOut();
    results();
  end
endmodule // tb
